// *** hdl/tcaoi_defines.vh ***
// Purpose: constants for the channel/adjust opcode interpreter
// Assumes: 16-bit opcodes, upper byte is the command
// Notes: definitions only
`ifndef TCAOI_DEFINES_VH
`define TCAOI_DEFINES_VH
// ------------------------------------------------------------
// commands
// ------------------------------------------------------------
`define TCAOI_CMD_EN_CH 8'h40
`define TCAOI_CMD_DIS_CH 8'h41
`define TCAOI_CMD_EN_ALL 8'h42
`define TCAOI_CMD_DIS_ALL 8'h43
`define TCAOI_CMD_WR_PAT 8'h44
`define TCAOI_CMD_RD_PAT 8'h45
`define TCAOI_CMD_WR_PAT32 8'h46
`define TCAOI_CMD_RD_PAT32 8'h47
`define TCAOI_CMD_WR_GOFS 8'h50
`define TCAOI_CMD_RD_GOFS 8'h51
`define TCAOI_CMD_WR_CHADJ 8'h52
`define TCAOI_CMD_RD_CHADJ 8'h53
`define TCAOI_CMD_WR_RC 8'h54
`define TCAOI_CMD_RD_RC 8'h55
`define TCAOI_CMD_SAVE_RC 8'h56
`define TCAOI_CMD_RD_ID 8'h60
`define TCAOI_CMD_RD_FW 8'h61
`define TCAOI_CMD_RST_LOOP 8'h62
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define TCAOI_COARSE_W 11
`define TCAOI_FINE_W 5
`define TCAOI_ADJ_W 8
`define TCAOI_RC_W 12
`define TCAOI_CHIP_IDX_W 2
`define TCAOI_CHIP_NIB_W 4
`define TCAOI_EN_RST 1'b1
`define TCAOI_RC_RST 12'h000
`define TCAOI_PULSE_CYC 4'h8
`endif

// *** hdl/tcaoi_pulse.v ***
// Purpose: fixed-length pulse stretcher for one-shot actions
// Assumes: trigger is a one-cycle strobe on mclk_i
// Notes: retrigger restarts the count
`timescale 1ns/1ps
`default_nettype none
`include "tcaoi_defines.vh"
module tcaoi_pulse (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  input wire ce_i,
  // trigger and output
  input wire trig_i,
  output reg pulse_o
);
  reg [3:0] cnt_reg;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= 4'h0;
      pulse_o <= 1'b0;
    end else if (ce_i) begin
      if (trig_i) begin
        cnt_reg <= `TCAOI_PULSE_CYC;
        pulse_o <= 1'b1;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
        pulse_o <= (cnt_reg != 4'h1);
      end else begin
        pulse_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/tcaoi_sync.v ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock mclk_i
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module tcaoi_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire mclk_i,
  input wire rstn_i,
  input wire ce_i,
  // data
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_reg;
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** hdl/tcaoi_top.v ***
// Purpose: opcode interpreter for channel enable, adjust and misc commands
// Assumes: host gives opcode/data words as one-cycle strobes on mclk_i
// Notes: fw revision byte and chip revision nibble are pins, synchronised
//
// How it works
// - opcode 40nn enables channel nn, 0 to 1f on wide variant
// - opcode 41nn disables channel nn, narrow variant ends at 0f
// - opcode 42xx enables every channel, low byte ignored
// - opcode 43xx disables every channel, low byte ignored
// - enable changes apply at any time, acquisition need not stop
// - word 0 bit k is channel k, word 1 bit k is channel 16+k
// - 45xx offers the enable pattern as one or two words, then waits
// - 460n takes two words as chip n's 32-channel enable pattern
// - 470n offers chip n's 32-channel pattern as two words
// - command processing stalls until the exact word count has moved
// - 50xx takes 11-bit coarse then 5-bit fine global offset
// - 51xx returns coarse offset then fine offset
// - 52nn takes one word, low 8 bits set channel nn offset
// - 53nn returns channel nn offset in low 8 bits
// - 540n takes one word, low 12 bits set chip n rc calibration
// - 550n makes one transfer holding chip n rc calibration
// - 56xx stores rc adjustment to nonvolatile memory, no data
// - 600n returns chip n id word, low nibble is chip revision
// - 61xx returns firmware revision in low 8 bits
// - 62xx resets the pll and dll of the chips, no data
`timescale 1ns/1ps
`default_nettype none
`include "tcaoi_defines.vh"
module tcaoi_top #(
  parameter NCH = 32,
  parameter NCHIP = 4,
  parameter [15:0] ID_BASE = 16'ha5c0 // arbitrary value
) (
  // clock, reset, enable
  input wire mclk_i,
  input wire rstn_i,
  input wire ce_i,
  // host word port
  input wire wr_i,
  input wire [15:0] wdata_i,
  input wire rd_i,
  output reg [15:0] rdata_o,
  output reg rvalid_o,
  output reg busy_o,
  output reg err_o,
  // pins
  input wire [7:0] fw_rev_i,
  input wire [3:0] chip_rev_i,
  // settings
  output reg [NCH-1:0] ch_en_o,
  output reg [32*NCHIP-1:0] chip_en_o,
  output reg [`TCAOI_COARSE_W-1:0] coarse_ofs_o,
  output reg [`TCAOI_FINE_W-1:0] fine_ofs_o,
  output reg [`TCAOI_ADJ_W*NCH-1:0] ch_adj_o,
  output reg [`TCAOI_RC_W*NCHIP-1:0] rc_cal_o,
  output reg rc_save_o,
  output reg loop_rst_o
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WR = 2'h1;
  localparam ST_RD = 2'h2;
  localparam [1:0] NW = (NCH > 16) ? 2'h2 : 2'h1;

  reg [1:0] state_reg;
  reg [7:0] cmd_reg;
  reg [7:0] idx_reg;
  reg [1:0] left_reg;
  reg [15:0] hold_reg;
  reg save_trig_reg;
  reg rst_trig_reg;
  reg [`TCAOI_ADJ_W-1:0] adj_mem [0:NCH-1];
  wire [7:0] fw_s;
  wire [3:0] rev_s;
  wire save_pulse;
  wire loop_pulse;
  wire [7:0] opc = wdata_i[15:8];
  wire [7:0] opi = wdata_i[7:0];
  integer i;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // bits needed to index n items
  function integer idx_bits;
    input integer n;
    integer k;
    begin
      idx_bits = 1;
      for (k = 2; k < n; k = k * 2)
        idx_bits = idx_bits + 1;
    end
  endfunction

  // narrow variant indexes with fewer bits
  localparam CH_IDX_W = idx_bits(NCH);

  // number of data words for a command, read flag in bit 2
  function [2:0] words_of;
    input [7:0] c;
    begin
      case (c)
        `TCAOI_CMD_WR_PAT: words_of = {1'b0, NW};
        `TCAOI_CMD_RD_PAT: words_of = {1'b1, NW};
        `TCAOI_CMD_WR_PAT32: words_of = 3'h2;
        `TCAOI_CMD_RD_PAT32: words_of = 3'h6;
        `TCAOI_CMD_WR_GOFS: words_of = 3'h2;
        `TCAOI_CMD_RD_GOFS: words_of = 3'h6;
        `TCAOI_CMD_WR_CHADJ: words_of = 3'h1;
        `TCAOI_CMD_RD_CHADJ: words_of = 3'h5;
        `TCAOI_CMD_WR_RC: words_of = 3'h1;
        `TCAOI_CMD_RD_RC: words_of = 3'h5;
        `TCAOI_CMD_RD_ID: words_of = 3'h5;
        `TCAOI_CMD_RD_FW: words_of = 3'h5;
        default: words_of = 3'h0;
      endcase
    end
  endfunction

  // index in range for channel or chip commands
  function idx_ok;
    input [7:0] c;
    input [7:0] n;
    begin
      case (c)
        `TCAOI_CMD_EN_CH, `TCAOI_CMD_DIS_CH,
        `TCAOI_CMD_WR_CHADJ, `TCAOI_CMD_RD_CHADJ: idx_ok = (n < NCH);
        `TCAOI_CMD_WR_PAT32, `TCAOI_CMD_RD_PAT32, `TCAOI_CMD_WR_RC,
        `TCAOI_CMD_RD_RC, `TCAOI_CMD_RD_ID: idx_ok = (n < NCHIP);
        default: idx_ok = 1'b1;
      endcase
    end
  endfunction

  // ------------------------------------------------------------
  // opcode decode
  // ------------------------------------------------------------
  // length and direction of the data phase
  wire [2:0] op_words;
  wire [1:0] op_cnt;
  wire op_rd;
  wire op_ok;
  wire [CH_IDX_W-1:0] ch_sel;
  wire [`TCAOI_CHIP_IDX_W-1:0] chip_sel;
  assign op_words = words_of(opc);
  assign op_cnt = op_words[1:0];
  assign op_rd = op_words[2];
  assign op_ok = idx_ok(opc, opi);
  assign ch_sel = idx_reg[CH_IDX_W-1:0];
  assign chip_sel = idx_reg[`TCAOI_CHIP_IDX_W-1:0];

  // ------------------------------------------------------------
  // pin synchronisers and action pulses
  // ------------------------------------------------------------
  tcaoi_sync #(.W(8)) u_fw_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(fw_rev_i),
    .q_o(fw_s)
  );
  tcaoi_sync #(.W(4)) u_rev_sync (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .d_i(chip_rev_i),
    .q_o(rev_s)
  );
  tcaoi_pulse u_save (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .trig_i(save_trig_reg),
    .pulse_o(save_pulse)
  );
  tcaoi_pulse u_loop (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .trig_i(rst_trig_reg),
    .pulse_o(loop_pulse)
  );

  // ------------------------------------------------------------
  // read word selection
  // ------------------------------------------------------------
  reg [15:0] rword;
  reg [31:0] pat32;
  always @* begin
    rword = 16'h0000;
    pat32 = chip_en_o[32*chip_sel +: 32];
    case (cmd_reg)
      `TCAOI_CMD_RD_PAT: begin
        if (left_reg == NW)
          rword = ch_en_o[15:0];
        else
          rword = ch_en_o[NCH-1 -: 16];
      end
      `TCAOI_CMD_RD_PAT32: begin
        rword = (left_reg == 2'h2) ? pat32[15:0] : pat32[31:16];
      end
      `TCAOI_CMD_RD_GOFS: begin
        if (left_reg == 2'h2)
          rword = {{(16-`TCAOI_COARSE_W){1'b0}}, coarse_ofs_o};
        else
          rword = {{(16-`TCAOI_FINE_W){1'b0}}, fine_ofs_o};
      end
      `TCAOI_CMD_RD_CHADJ: rword = {8'h00, adj_mem[ch_sel]};
      `TCAOI_CMD_RD_RC: begin
        rword = {4'h0, rc_cal_o[`TCAOI_RC_W*idx_reg[`TCAOI_CHIP_IDX_W-1:0]
          +: `TCAOI_RC_W]};
      end
      `TCAOI_CMD_RD_ID: rword = {ID_BASE[15:4], rev_s};
      `TCAOI_CMD_RD_FW: rword = {8'h00, fw_s};
      default: rword = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // interpreter
  // ------------------------------------------------------------
  always @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 8'h00;
      idx_reg <= 8'h00;
      left_reg <= 2'h0;
      hold_reg <= 16'h0000;
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
      busy_o <= 1'b0;
      err_o <= 1'b0;
      ch_en_o <= {NCH{`TCAOI_EN_RST}};
      chip_en_o <= {(32*NCHIP){`TCAOI_EN_RST}};
      coarse_ofs_o <= {`TCAOI_COARSE_W{1'b0}};
      fine_ofs_o <= {`TCAOI_FINE_W{1'b0}};
      ch_adj_o <= {(`TCAOI_ADJ_W*NCH){1'b0}};
      rc_cal_o <= {NCHIP{`TCAOI_RC_RST}};
      save_trig_reg <= 1'b0;
      rst_trig_reg <= 1'b0;
      rc_save_o <= 1'b0;
      loop_rst_o <= 1'b0;
      for (i = 0; i < NCH; i = i + 1)
        adj_mem[i] <= {`TCAOI_ADJ_W{1'b0}};
    end else if (ce_i) begin
      save_trig_reg <= 1'b0;
      rst_trig_reg <= 1'b0;
      rc_save_o <= save_pulse;
      loop_rst_o <= loop_pulse;
      case (state_reg)
        ST_IDLE: begin
          rvalid_o <= 1'b0;
          if (wr_i) begin
            cmd_reg <= opc;
            idx_reg <= opi;
            err_o <= !op_ok;
            // a bad index drops the command and its data phase
            if (op_ok) begin
              case (opc)
                `TCAOI_CMD_EN_CH: ch_en_o[opi[CH_IDX_W-1:0]] <= 1'b1;
                `TCAOI_CMD_DIS_CH: ch_en_o[opi[CH_IDX_W-1:0]] <= 1'b0;
                `TCAOI_CMD_EN_ALL: ch_en_o <= {NCH{1'b1}};
                `TCAOI_CMD_DIS_ALL: ch_en_o <= {NCH{1'b0}};
                `TCAOI_CMD_SAVE_RC: save_trig_reg <= 1'b1;
                `TCAOI_CMD_RST_LOOP: rst_trig_reg <= 1'b1;
                default: ;
              endcase
              if (op_cnt != 2'h0) begin
                left_reg <= op_cnt;
                busy_o <= 1'b1;
                state_reg <= op_rd ? ST_RD : ST_WR;
              end
            end
          end
        end
        ST_WR: begin
          if (wr_i) begin
            left_reg <= left_reg - 2'h1;
            // the first word of a 46nn or 50xx pair waits in hold_reg, 44xx words land at once
            case (cmd_reg)
              `TCAOI_CMD_WR_PAT: begin
                if (left_reg == NW)
                  ch_en_o[15:0] <= wdata_i;
                else
                  ch_en_o[NCH-1 -: 16] <= wdata_i;
              end
              `TCAOI_CMD_WR_PAT32: begin
                if (left_reg == 2'h2)
                  hold_reg <= wdata_i;
                else
                  chip_en_o[32*chip_sel +: 32] <= {wdata_i, hold_reg};
              end
              `TCAOI_CMD_WR_GOFS: begin
                if (left_reg == 2'h2)
                  hold_reg <= wdata_i;
                else begin
                  coarse_ofs_o <= hold_reg[`TCAOI_COARSE_W-1:0];
                  fine_ofs_o <= wdata_i[`TCAOI_FINE_W-1:0];
                end
              end
              `TCAOI_CMD_WR_CHADJ: begin
                adj_mem[ch_sel] <= wdata_i[`TCAOI_ADJ_W-1:0];
                ch_adj_o[`TCAOI_ADJ_W*ch_sel +: `TCAOI_ADJ_W]
                  <= wdata_i[`TCAOI_ADJ_W-1:0];
              end
              `TCAOI_CMD_WR_RC: begin
                rc_cal_o[`TCAOI_RC_W*idx_reg[`TCAOI_CHIP_IDX_W-1:0]
                  +: `TCAOI_RC_W] <= wdata_i[`TCAOI_RC_W-1:0];
              end
              default: ;
            endcase
            if (left_reg == 2'h1) begin
              busy_o <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_RD: begin
          // load once and hold while offered, so a moving pin cannot tear the word
          if (!rvalid_o) begin
            rdata_o <= rword;
            rvalid_o <= 1'b1;
          end
          if (rd_i && rvalid_o) begin
            left_reg <= left_reg - 2'h1;
            rvalid_o <= 1'b0;
            if (left_reg == 2'h1) begin
              busy_o <= 1'b0;
              state_reg <= ST_IDLE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: self-checking bench for the opcode interpreter
// Assumes: wide variant, 32 channels and 4 chips
// Notes: ce_i lowered in one scenario, pins moved mid-run
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam [15:0] ID_BASE = 16'h5a30; // arbitrary value
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] fw_rev_i = 8'h3c;
  logic [3:0] chip_rev_i = 4'h7;
  logic ce_i = 1'b1;
  logic wr_i, rd_i, rvalid_o, busy_o, err_o, rc_save_o, loop_rst_o;
  logic [15:0] wdata_i, rdata_o, w;
  logic [31:0] ch_en_o;
  logic [127:0] chip_en_o;
  logic [10:0] coarse_ofs_o;
  logic [4:0] fine_ofs_o;
  logic [255:0] ch_adj_o;
  logic [47:0] rc_cal_o;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #5 mclk_i = ~mclk_i;
  tcaoi_top #(.NCH(32), .NCHIP(4), .ID_BASE(ID_BASE)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .busy_o(busy_o), .err_o(err_o), .fw_rev_i(fw_rev_i),
    .chip_rev_i(chip_rev_i), .ch_en_o(ch_en_o), .chip_en_o(chip_en_o),
    .coarse_ofs_o(coarse_ofs_o), .fine_ofs_o(fine_ofs_o), .ch_adj_o(ch_adj_o),
    .rc_cal_o(rc_cal_o), .rc_save_o(rc_save_o), .loop_rst_o(loop_rst_o));
  tcaoi_host h (.mclk_i(mclk_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .busy_o(busy_o),
    .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i));
  // ----------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_chan();
    h.op(16'h43a5);
    chk(ch_en_o, 32'h0);
    h.op(16'h401f);
    h.op(16'h4000);
    chk(ch_en_o, 32'h80000001);
    h.op(16'h4020);
    chk(err_o, 1'b1);
    chk(ch_en_o, 32'h80000001);
    h.op(16'h42ee);
    chk(ch_en_o, 32'hffffffff);
    h.op(16'h4105);
    chk(ch_en_o, 32'hffffffdf);
    h.op(16'h41ff);
    chk(ch_en_o, 32'hffffffdf);
    $display("test chan done");
  endtask
  task automatic t_pat();
    h.op(16'h4400);
    h.put(16'h1234);
    chk(busy_o, 1'b1);
    h.put(16'habcd);
    h.idle();
    chk(ch_en_o, 32'habcd1234);
    h.op(16'h4500);
    h.get(w);
    chk(w, 16'h1234);
    h.get(w);
    chk(w, 16'habcd);
    $display("test pattern done");
  endtask
  task automatic t_chip();
    h.op(16'h4602);
    h.put(16'h0f0f);
    h.put(16'hf0f0);
    h.idle();
    chk(chip_en_o[64+:32], 32'hf0f00f0f);
    h.op(16'h4702);
    h.get(w);
    chk(w, 16'h0f0f);
    h.get(w);
    chk(w, 16'hf0f0);
    h.op(16'h4604);
    chk(err_o, 1'b1);
    chk(busy_o, 1'b0);
    $display("test chip done");
  endtask
  task automatic t_adj();
    h.slow = 3;
    h.op(16'h5000);
    h.put(16'hf7ff);
    h.put(16'hffe3);
    h.idle();
    chk(coarse_ofs_o, 11'h7ff);
    chk(fine_ofs_o, 5'h03);
    h.op(16'h5100);
    h.get(w);
    chk(w[10:0], 11'h7ff);
    h.get(w);
    chk(w[4:0], 5'h03);
    h.op(16'h521f);
    h.put(16'hab5a);
    h.idle();
    chk(ch_adj_o[248+:8], 8'h5a);
    h.op(16'h531f);
    h.get(w);
    chk(w[7:0], 8'h5a);
    h.op(16'h5403);
    h.put(16'h9abc);
    h.idle();
    chk(rc_cal_o[36+:12], 12'habc);
    h.op(16'h5503);
    h.get(w);
    chk(w[11:0], 12'habc);
    h.slow = 0;
    $display("test adjust done");
  endtask
  task automatic t_misc();
    h.op(16'h5600);
    @(negedge mclk_i);
    chk(rc_save_o, 1'b1);
    repeat (7) @(negedge mclk_i);
    chk(rc_save_o, 1'b1);
    @(negedge mclk_i);
    chk(rc_save_o, 1'b0);
    h.op(16'h6200);
    @(negedge mclk_i);
    chk(loop_rst_o, 1'b1);
    repeat (7) @(negedge mclk_i);
    chk(loop_rst_o, 1'b1);
    @(negedge mclk_i);
    chk(loop_rst_o, 1'b0);
    h.op(16'h6001);
    h.get(w);
    chk(w, {ID_BASE[15:4], chip_rev_i});
    h.op(16'h61aa);
    h.get(w);
    chk(w[7:0], fw_rev_i);
    $display("test misc done");
  endtask
  task automatic t_ce();
    h.op(16'h42ff);
    fw_rev_i = 8'hc3;
    chip_rev_i = 4'h2;
    ce_i = 1'b0;
    h.op(16'h4300);
    chk(ch_en_o, 32'hffffffff);
    ce_i = 1'b1;
    h.op(16'h6100);
    h.get(w);
    chk(w[7:0], 8'hc3);
    h.op(16'h6003);
    h.get(w);
    chk(w, {ID_BASE[15:4], 4'h2});
    h.op(16'h6004);
    chk(err_o, 1'b1);
    chk(busy_o, 1'b0);
    $display("test enable done");
  endtask
  task automatic t_rst();
    h.op(16'h4400);
    h.put(16'h0000);
    rstn_i = 1'b0;
    @(negedge mclk_i);
    chk(busy_o, 1'b0);
    chk(ch_en_o, 32'hffffffff);
    @(negedge mclk_i);
    rstn_i = 1'b1;
    @(negedge mclk_i);
    h.op(16'h4501);
    h.get(w);
    chk(w, 16'hffff);
    h.get(w);
    chk(w, 16'hffff);
    $display("test reset done");
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    t_chan();
    t_pat();
    t_chip();
    t_adj();
    t_misc();
    t_ce();
    t_rst();
    results();
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
  end
endmodule
`default_nettype wire

// *** sim/tcaoi_chk_sva.sv ***
// Purpose: port assertions for the opcode interpreter
// Assumes: ce_i stays high while an opcode is in flight
// Notes: bound into tcaoi_top
`timescale 1ns/1ps
`default_nettype none
module tcaoi_chk #(
  parameter NCH = 32,
  parameter NCHIP = 4
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // host port
  input wire logic wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic busy_o,
  input wire logic err_o,
  // settings
  input wire logic [NCH-1:0] ch_en_o,
  input wire logic [10:0] coarse_ofs_o,
  input wire logic rc_save_o,
  input wire logic loop_rst_o
);
  // ----------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------
  wire logic op_v = ce_i && wr_i && !busy_o;
  wire logic [7:0] cmd = wdata_i[15:8];
  wire logic [7:0] idx = wdata_i[7:0];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  en_one_a: assert property (op_v && cmd == 8'h40 && idx < NCH |->
    ##1 ch_en_o[$past(idx, 1)]) else $error("channel not enabled");
  dis_one_a: assert property (op_v && cmd == 8'h41 && idx < NCH |->
    ##1 !ch_en_o[$past(idx, 1)]) else $error("channel not disabled");
  en_all_a: assert property (op_v && cmd == 8'h42 |-> ##1 &ch_en_o)
    else $error("not all enabled");
  dis_all_a: assert property (op_v && cmd == 8'h43 |-> ##1 ch_en_o == '0)
    else $error("not all disabled");
  bad_idx_a: assert property (op_v && (cmd == 8'h40 || cmd == 8'h41) && idx >= NCH |->
    ##1 (err_o && ch_en_o == $past(ch_en_o, 1))) else $error("bad index acted on");
  pat_wait_a: assert property (op_v && cmd == 8'h44 |-> ##[1:2] busy_o)
    else $error("no data phase");
  rd_valid_a: assert property (op_v && cmd == 8'h45 |-> ##[1:3] rvalid_o)
    else $error("pattern word not offered");
  ofs_read_a: assert property (op_v && cmd == 8'h51 |->
    ##[1:3] (rvalid_o && rdata_o[10:0] == coarse_ofs_o)) else $error("coarse word wrong");
  save_pulse_a: assert property (op_v && cmd == 8'h56 |-> ##[1:3] rc_save_o)
    else $error("no save pulse");
  loop_pulse_a: assert property (op_v && cmd == 8'h62 |-> ##[1:3] loop_rst_o)
    else $error("no loop reset pulse");
  cover property (op_v && cmd == 8'h44);
  cover property (rvalid_o && rd_i);
  cover property (op_v && cmd == 8'h56);
endmodule
bind tcaoi_top tcaoi_chk #(.NCH(NCH), .NCHIP(NCHIP)) u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
  .ce_i(ce_i), .wr_i(wr_i), .wdata_i(wdata_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .busy_o(busy_o), .err_o(err_o), .ch_en_o(ch_en_o),
  .coarse_ofs_o(coarse_ofs_o), .rc_save_o(rc_save_o), .loop_rst_o(loop_rst_o));
`default_nettype wire

// *** sim/tcaoi_host.sv ***
// Purpose: host model writing and reading the command data word
// Assumes: requests change at the falling edge
// Notes: slow adds idle cycles before each transfer
`timescale 1ns/1ps
`default_nettype none
module tcaoi_host (
  // clock
  input wire logic mclk_i,
  // answers
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic busy_o,
  // requests
  output logic wr_i,
  output logic [15:0] wdata_i,
  output logic rd_i
);
  int slow = 0;
  initial begin
    wr_i = 1'b0;
    rd_i = 1'b0;
    wdata_i = 16'h0000;
  end
  // released data shows the inverse word
  task automatic put(input logic [15:0] v);
    repeat (slow) @(negedge mclk_i);
    @(negedge mclk_i);
    wr_i = 1'b1;
    wdata_i = v;
    @(negedge mclk_i);
    wr_i = 1'b0;
    wdata_i = ~v;
  endtask
  task automatic idle();
    for (int i = 0; i < 50 && busy_o !== 1'b0; i++) @(negedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic op(input logic [15:0] v);
    idle();
    put(v);
    @(negedge mclk_i);
  endtask
  task automatic get(output logic [15:0] v);
    repeat (slow) @(negedge mclk_i);
    for (int i = 0; i < 50 && rvalid_o !== 1'b1; i++) @(negedge mclk_i);
    v = rdata_o;
    rd_i = 1'b1;
    @(negedge mclk_i);
    rd_i = 1'b0;
  endtask
endmodule
`default_nettype wire
